// ===== logic/mod_decoder.sv
// Purpose: Decode a slice of multiply and multiply-accumulate words
// Assumes: instr_word and dreg_flat come from core logic on clk_sys
// Notes: All outputs registered, one cycle after instr_valid
`timescale 1ns/100ps
`include "mod_map.svh"
module mod_decoder
  import mod_pkg::*;
(
  input wire logic clk_sys, // 50 MHz core clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic instr_valid, // Word present this cycle
  input wire logic [31:0] instr_word, // Instruction word
  input wire logic [255:0] dreg_flat, // Data registers 0..7
  output logic claimed_q, // Word decoded here
  output logic unclaimed_q, // Word passed on
  output mod_op_type op_q, // Operation kind
  output logic acc_write_q, // Accumulator update strobe
  output logic upper_accumulator_q, // Upper accumulator targeted
  output logic lower_accumulator_q, // Lower accumulator targeted
  output logic acc_subtract_q, // Subtract from accumulator
  output logic write_upper_half_q, // Write upper half of dest
  output logic integer_high_half_option_q, // Integer high half
  output logic mixed_mode_q, // Mixed operand treatment
  output logic unsigned_fraction_option_q, // Unsigned fractions
  output logic parallel_q, // Parallel load/store form
  output logic [1:0] half_sel_q, // Operand halves select
  output logic [2:0] dest_q, // Destination register
  output logic [2:0] src0_q, // Left source register
  output logic [2:0] src1_q, // Right source register
  output logic [15:0] mul_a_q, // Multiplier input one
  output logic [15:0] mul_b_q // Multiplier input two
);
  // ----------------------------------------------------------------
  // Reset release synchroniser
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Field extraction and group match
  // ----------------------------------------------------------------
  logic [15:0] first_hw; // First halfword, parallel bit cleared
  logic [15:0] second_hw; // Second halfword
  logic is_par; // Parallel-issue marker
  logic hit_sub; // Upper subtract group
  logic hit_def; // Lower load, default
  logic hit_uns; // Lower load, unsigned fraction
  logic [1:0] hsel; // Half select of the matched layout
  logic [2:0] src0_w;
  logic [2:0] src1_w;
  logic [15:0] half_a;
  logic [15:0] half_b;
  always_comb begin
    second_hw = instr_word[15:0];
    is_par = instr_word[`MOD_PAR_BIT];
    first_hw = instr_word[31:16] & `MOD_PAR_MASK;
    hit_sub = (first_hw == `MOD_HI_SUB_INT_MIX) &&
      (second_hw[`MOD_FIX_W_HI:`MOD_FIX_W_LO] ==
       `MOD_FIX_W_VAL);
    hit_def = (first_hw == `MOD_HI_LOAD_DEF) &&
      (second_hw[`MOD_FIX_D_HI:`MOD_FIX_D_LO] ==
       `MOD_FIX_D_VAL);
    hit_uns = (first_hw == `MOD_HI_LOAD_UNS) &&
      (second_hw[`MOD_FIX_D_HI:`MOD_FIX_D_LO] ==
       `MOD_FIX_D_VAL);
    // Half field sits high for half-register forms
    if (hit_sub) begin
      hsel = second_hw[`MOD_HALF_W_HI:`MOD_HALF_W_LO];
    end else begin
      hsel = second_hw[`MOD_HALF_D_HI:`MOD_HALF_D_LO];
    end
    src0_w = second_hw[`MOD_SRC0_HI:`MOD_SRC0_LO];
    src1_w = second_hw[`MOD_SRC1_HI:`MOD_SRC1_LO];
  end

  // Left operand: bit 1 of half select picks its half
  mod_half_pick u_pick_a (
    .dreg_flat(dreg_flat),
    .reg_idx(src0_w),
    .use_high(hsel[1]),
    .half_val(half_a)
  );

  // Right operand: bit 0 of half select picks its half
  mod_half_pick u_pick_b (
    .dreg_flat(dreg_flat),
    .reg_idx(src1_w),
    .use_high(hsel[0]),
    .half_val(half_b)
  );

  // ----------------------------------------------------------------
  // Next decode outputs
  // ----------------------------------------------------------------
  logic hit;
  logic claimed_d, unclaimed_d, acc_write_d;
  logic upper_d, lower_d, sub_d, wuh_d, int_high_d, mix_d, uns_frac_d;
  logic par_d;
  mod_op_type op_d;
  logic [1:0] half_sel_d;
  logic [2:0] dest_d, src0_d, src1_d;
  logic [15:0] mul_a_d, mul_b_d;
  always_comb begin
    hit = instr_valid && (hit_sub || hit_def || hit_uns);
    claimed_d = hit;
    unclaimed_d = instr_valid && !hit;
    acc_write_d = hit;
    op_d = MOD_OP_NONE;
    upper_d = 1'b0;
    lower_d = 1'b0;
    sub_d = 1'b0;
    wuh_d = 1'b0;
    int_high_d = 1'b0;
    mix_d = 1'b0;
    uns_frac_d = 1'b0;
    par_d = 1'b0;
    half_sel_d = 2'h0;
    dest_d = 3'h0;
    src0_d = 3'h0;
    src1_d = 3'h0;
    mul_a_d = 16'h0000;
    mul_b_d = 16'h0000;
    if (hit) begin
      par_d = is_par;
      half_sel_d = hsel;
      dest_d = second_hw[`MOD_DEST_HI:`MOD_DEST_LO];
      src0_d = src0_w;
      src1_d = src1_w;
      mul_a_d = half_a;
      mul_b_d = half_b;
      if (hit_sub) begin
        // Upper accumulator subtract, upper half write
        op_d = MOD_OP_SUB_UPPER_HALF;
        upper_d = 1'b1;
        sub_d = 1'b1;
        wuh_d = 1'b1;
        int_high_d = 1'b1;
        mix_d = 1'b1;
      end else begin
        // Lower accumulator load, full even register write
        op_d = MOD_OP_LOAD_LOWER_FULL;
        lower_d = 1'b1;
        uns_frac_d = hit_uns;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      claimed_q <= 1'b0;
      unclaimed_q <= 1'b0;
      op_q <= MOD_OP_NONE;
      acc_write_q <= 1'b0;
      upper_accumulator_q <= 1'b0;
      lower_accumulator_q <= 1'b0;
      acc_subtract_q <= 1'b0;
      write_upper_half_q <= 1'b0;
      integer_high_half_option_q <= 1'b0;
      mixed_mode_q <= 1'b0;
      unsigned_fraction_option_q <= 1'b0;
      parallel_q <= 1'b0;
      half_sel_q <= 2'h0;
      dest_q <= 3'h0;
      src0_q <= 3'h0;
      src1_q <= 3'h0;
      mul_a_q <= 16'h0000;
      mul_b_q <= 16'h0000;
    end else begin
      claimed_q <= claimed_d;
      unclaimed_q <= unclaimed_d;
      op_q <= op_d;
      acc_write_q <= acc_write_d;
      upper_accumulator_q <= upper_d;
      lower_accumulator_q <= lower_d;
      acc_subtract_q <= sub_d;
      write_upper_half_q <= wuh_d;
      integer_high_half_option_q <= int_high_d;
      mixed_mode_q <= mix_d;
      unsigned_fraction_option_q <= uns_frac_d;
      parallel_q <= par_d;
      half_sel_q <= half_sel_d;
      dest_q <= dest_d;
      src0_q <= src0_d;
      src1_q <= src1_d;
      mul_a_q <= mul_a_d;
      mul_b_q <= mul_b_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Register file as it stood when the answered word was taken; the
  // source numbers of the answer index it, not last cycle's numbers
  logic [255:0] dreg_seen_q;
  always_ff @(posedge clk_sys) begin
    dreg_seen_q <= dreg_flat;
  end

  default clocking ck @(posedge clk_sys); endclocking
  default disable iff (!rst_n_q);

  sequence s_par_sub;
    instr_valid && instr_word[31:16] == 16'hc976 &&
      instr_word[13:9] == 5'h0c;
  endsequence
  sequence s_sub_out;
    claimed_q && parallel_q && op_q == MOD_OP_SUB_UPPER_HALF;
  endsequence

  AST_PAR_ACCEPT: assert property (s_par_sub |=> s_sub_out)
    else $error("parallel form not accepted");
  AST_HALF_A: assert property (claimed_q |-> mul_a_q ==
      (half_sel_q[1] ? dreg_seen_q[{src0_q, 5'h10} +: 16]
                     : dreg_seen_q[{src0_q, 5'h00} +: 16]))
    else $error("left operand half wrong");
  AST_HALF_B: assert property (claimed_q |-> mul_b_q ==
      (half_sel_q[0] ? dreg_seen_q[{src1_q, 5'h10} +: 16]
                     : dreg_seen_q[{src1_q, 5'h00} +: 16]))
    else $error("right operand half wrong");
  AST_DEST: assert property (instr_valid ##1 claimed_q |->
      dest_q == $past(instr_word[8:6]))
    else $error("destination field wrong");
  AST_SRC0: assert property (instr_valid ##1 claimed_q |->
      src0_q == $past(instr_word[5:3]))
    else $error("left source field wrong");
  AST_SRC1: assert property (instr_valid ##1 claimed_q |->
      src1_q == $past(instr_word[2:0]))
    else $error("right source field wrong");
  AST_SUB: assert property (op_q == MOD_OP_SUB_UPPER_HALF |->
      upper_accumulator_q && acc_subtract_q && write_upper_half_q &&
      integer_high_half_option_q && mixed_mode_q)
    else $error("upper subtract attributes wrong");
  AST_LOAD_DEF: assert property (instr_valid &&
      instr_word[31:16] == 16'hc00d && instr_word[15:11] == 5'h00
      |=> lower_accumulator_q && !unsigned_fraction_option_q &&
      !acc_subtract_q)
    else $error("default lower load wrong");
  AST_LOAD_UNS: assert property (instr_valid &&
      instr_word[31:16] == 16'hc08d && instr_word[15:11] == 5'h00
      |=> lower_accumulator_q && unsigned_fraction_option_q)
    else $error("unsigned lower load wrong");
  AST_UNCLAIMED: assert property (!instr_valid |=>
      !claimed_q && !acc_write_q && !unclaimed_q)
    else $error("update without a word");
  AST_EXCL: assert property (unclaimed_q |-> !acc_write_q &&
      op_q == MOD_OP_NONE)
    else $error("unclaimed word caused update");
endmodule : mod_decoder

// ===== logic/mod_map.svh
// Purpose: Constants of the multiply opcode decoder
// Assumes: Included by bare name
// Notes: Instruction word bits 31:16 hold the first fetched halfword
// Behaviour
// - Accept parallel-issue form, first halfword plus 0x0800
// - Half select: lo*lo, lo*hi, hi*lo, hi*hi
// - Destination field steers the result write
// - First source field feeds multiplier input one
// - Second source field feeds multiplier input two
// - Upper accumulator subtract, integer high half, mixed
// - Lower accumulator load, default signed fraction
// - Lower accumulator load, unsigned fraction operands
`ifndef MOD_MAP_SVH
`define MOD_MAP_SVH

// ----------------------------------------------------------------
// First halfword values of the decoded groups
// ----------------------------------------------------------------
`define MOD_HI_SUB_INT_MIX 16'hc176
`define MOD_HI_LOAD_DEF 16'hc00d
`define MOD_HI_LOAD_UNS 16'hc08d
`define MOD_PAR_BIT 27
`define MOD_PAR_MASK 16'hf7ff

// ----------------------------------------------------------------
// Second halfword field positions
// ----------------------------------------------------------------
`define MOD_HALF_W_HI 15
`define MOD_HALF_W_LO 14
`define MOD_HALF_D_HI 10
`define MOD_HALF_D_LO 9
`define MOD_DEST_HI 8
`define MOD_DEST_LO 6
`define MOD_SRC0_HI 5
`define MOD_SRC0_LO 3
`define MOD_SRC1_HI 2
`define MOD_SRC1_LO 0
`define MOD_FIX_W_HI 13
`define MOD_FIX_W_LO 9
`define MOD_FIX_W_VAL 5'h0c
`define MOD_FIX_D_HI 15
`define MOD_FIX_D_LO 11
`define MOD_FIX_D_VAL 5'h00

`endif

// ===== logic/mod_pkg.sv
// Purpose: Types of the multiply opcode decoder
// Assumes: Nothing
// Notes: Constants live in the map header
package mod_pkg;
  // Decoded operation kind
  typedef enum logic [1:0] {
    MOD_OP_NONE,
    MOD_OP_SUB_UPPER_HALF,
    MOD_OP_LOAD_LOWER_FULL
  } mod_op_type;
endpackage : mod_pkg

// ===== logic/mod_half_pick.sv
// Purpose: Pick one data register and one 16-bit half of it
// Assumes: Eight 32-bit data registers packed low register first
// Notes: Purely combinational
`timescale 1ns/100ps
module mod_half_pick
  import mod_pkg::*;
(
  input wire logic [255:0] dreg_flat, // All data registers
  input wire logic [2:0] reg_idx, // Register number
  input wire logic use_high, // High half when set
  output logic [15:0] half_val // Chosen half
);
  // ----------------------------------------------------------------
  // Register then half selection
  // ----------------------------------------------------------------
  logic [31:0] word;
  always_comb begin
    word = dreg_flat[{reg_idx, 5'h00} +: 32];
    half_val = use_high ? word[31:16] : word[15:0];
  end
endmodule : mod_half_pick

// ===== verif/mod_core_model.sv
// Purpose: Core-side model that supplies the data register file
// Assumes: Register n sits at bits [32n+31:32n]
// Notes: Each half holds a marker byte and the register number
`timescale 1ns/100ps
module mod_core_model
  import mod_pkg::*;
(
  output logic [255:0] dreg_flat // Data registers 0..7
);
  // ------------------------------------------------------------
  // Register contents
  // ------------------------------------------------------------
  // High half bb, low half 11, so a wrong half or register shows
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      dreg_flat[32*n +: 32] = {8'hbb, 5'h00, 3'(n), 8'h11, 5'h00, 3'(n)};
    end
  end
endmodule : mod_core_model

// ===== verif/tb_mod_decoder.sv
// Purpose: Self-checking bench of the multiply opcode decoder
// Assumes: Answer one cycle after the word
// Notes: Words are driven 1 ns after the rising edge
`timescale 1ns/100ps
module tb_mod_decoder
  import mod_pkg::*;
;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0; // 50 MHz clock
  logic arst_n = 1'b0; // Reset, active low
  logic instr_valid = 1'b0; // Word strobe
  logic [31:0] instr_word = 32'h00000000; // Word under test
  logic [255:0] dreg_flat; // From the core model
  logic claimed_q, unclaimed_q, acc_write_q, upper_accumulator_q;
  logic lower_accumulator_q, acc_subtract_q, write_upper_half_q;
  logic integer_high_half_option_q, mixed_mode_q, parallel_q;
  logic unsigned_fraction_option_q;
  mod_op_type op_q; // Operation kind
  logic [1:0] half_sel_q; // Half select
  logic [2:0] dest_q, src0_q, src1_q; // Register fields
  logic [15:0] mul_a_q, mul_b_q; // Operand halves
  int err_count = 0; // Mismatches
  int num_checks = 0; // Comparisons
  // ------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------
  mod_core_model mod_core_model_inst (.dreg_flat(dreg_flat));
  mod_decoder mod_decoder_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .dreg_flat(dreg_flat),
    .claimed_q(claimed_q), .unclaimed_q(unclaimed_q), .op_q(op_q),
    .acc_write_q(acc_write_q),
    .upper_accumulator_q(upper_accumulator_q),
    .lower_accumulator_q(lower_accumulator_q),
    .acc_subtract_q(acc_subtract_q),
    .write_upper_half_q(write_upper_half_q),
    .integer_high_half_option_q(integer_high_half_option_q),
    .mixed_mode_q(mixed_mode_q),
    .unsigned_fraction_option_q(unsigned_fraction_option_q),
    .parallel_q(parallel_q), .half_sel_q(half_sel_q), .dest_q(dest_q),
    .src0_q(src0_q), .src1_q(src1_q), .mul_a_q(mul_a_q),
    .mul_b_q(mul_b_q));
  // Clock generator, 20 ns period
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // Compare one value, zero-extended
  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // Expected half of a register in the core model
  function automatic logic [15:0] exp_half(logic [2:0] n, logic hi);
    return {hi ? 8'hbb : 8'h11, 5'h00, n};
  endfunction : exp_half
  // Present one word, then judge the registered answer
  task automatic run(input logic [31:0] w, input logic c,
                     input mod_op_type op);
    logic sub;
    logic [1:0] hs;
    sub = (op == MOD_OP_SUB_UPPER_HALF);
    hs = c ? (sub ? w[15:14] : w[10:9]) : 2'h0;
    instr_word = w;
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    cmp("claimed", c, claimed_q);
    cmp("unclaimed", !c, unclaimed_q);
    cmp("acc_write", c, acc_write_q);
    cmp("op", op, op_q);
    cmp("upper", sub, upper_accumulator_q);
    cmp("subtract", sub, acc_subtract_q);
    cmp("wr_upper", sub, write_upper_half_q);
    cmp("int_high", sub, integer_high_half_option_q);
    cmp("mixed", sub, mixed_mode_q);
    cmp("lower", c && !sub, lower_accumulator_q);
    cmp("uns_frac", c && w[23], unsigned_fraction_option_q);
    cmp("par", c && w[27], parallel_q);
    cmp("half", hs, half_sel_q);
    cmp("dest", c ? w[8:6] : 3'h0, dest_q);
    cmp("src0", c ? w[5:3] : 3'h0, src0_q);
    cmp("src1", c ? w[2:0] : 3'h0, src1_q);
    cmp("mul_a", c ? exp_half(w[5:3], hs[1]) : 16'h0000, mul_a_q);
    cmp("mul_b", c ? exp_half(w[2:0], hs[0]) : 16'h0000, mul_b_q);
  endtask : run
  // Idle cycle, claimed and unclaimed flags must fall back to zero
  task automatic idle(input string nm);
    instr_valid = 1'b0;
    @(posedge clk_sys);
    #1;
    cmp("idle_claim", 1'b0, claimed_q | unclaimed_q);
    $display("test %s done", nm);
  endtask : idle
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Lower accumulator load, every half select, back to back
  task automatic t_load_default();
    for (int h = 0; h < 4; h++) begin
      run({16'hc00d, 5'h00, 2'(h), 3'(2*h), 3'(7-h), 3'(h+3)}, 1'b1,
          MOD_OP_LOAD_LOWER_FULL);
    end
    idle("load_default");
  endtask : t_load_default
  // Upper accumulator subtract, every half select
  task automatic t_sub_upper();
    for (int h = 0; h < 4; h++) begin
      run({16'hc176, 2'(h), 5'h0c, 3'(7-h), 3'(h), 3'(5-h)}, 1'b1,
          MOD_OP_SUB_UPPER_HALF);
    end
    idle("sub_upper");
  endtask : t_sub_upper
  // Unsigned fractions, plus the parallel forms of each group
  task automatic t_uns_parallel();
    run(32'hc08d06d1, 1'b1, MOD_OP_LOAD_LOWER_FULL);
    run(32'hc88d0299, 1'b1, MOD_OP_LOAD_LOWER_FULL);
    run(32'hc80d0455, 1'b1, MOD_OP_LOAD_LOWER_FULL);
    run(32'hc976d87a, 1'b1, MOD_OP_SUB_UPPER_HALF);
    idle("uns_parallel");
  endtask : t_uns_parallel
  // Words just outside the decoded ranges
  task automatic t_unclaimed();
    run(32'hc00e0000, 1'b0, MOD_OP_NONE);
    run(32'hc00d0800, 1'b0, MOD_OP_NONE);
    run(32'hc1761800 ^ 32'h00000200, 1'b0, MOD_OP_NONE);
    run(32'hc1860000, 1'b0, MOD_OP_NONE);
    idle("unclaimed");
  endtask : t_unclaimed
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_load_default();
    t_sub_upper();
    t_uns_parallel();
    t_unclaimed();
    final_report();
  end
  // Cuts a hang short
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    final_report();
  end
endmodule : tb_mod_decoder
